// ===== sff_pkg.sv
package sff_pkg;

    // ==========================================================
    // instruction codes that change the lane use
    // ==========================================================
    localparam logic [7:0] SFF_OP_DUAL_OUT = 8'h3B;
    localparam logic [7:0] SFF_OP_DUAL_IO = 8'hBB;
    localparam logic [7:0] SFF_OP_QUAD_OUT = 8'h6B;
    localparam logic [7:0] SFF_OP_QUAD_IO = 8'hEB;
    localparam logic [7:0] SFF_OP_QUAD_WORD = 8'hE7;
    localparam logic [7:0] SFF_OP_QUAD_OCTAL = 8'hE3;

    // ==========================================================
    // sizes and reset values
    // ==========================================================
    localparam int SFF_BYTE_W = 8;
    localparam int SFF_TX_DEPTH = 16;
    localparam int SFF_SYNC_W = 6;
    localparam logic [7:0] SFF_IDLE_BYTE = 8'hFF;
    localparam logic [3:0] SFF_BITS_RST = 4'h0;
    localparam logic [3:0] SFF_BITS_PER_BYTE = 4'h8;
    localparam logic [SFF_SYNC_W-1:0] SFF_SYNC_RST = 6'h3F;

    // status lock encodings
    localparam logic [1:0] SFF_LOCK_HW = 2'h1;

    // ==========================================================
    // types
    // ==========================================================
    typedef enum logic [2:0] {
        SFF_ST_IDLE = 3'b001,
        SFF_ST_INSTR = 3'b010,
        SFF_ST_BODY = 3'b100
    } sff_state_e;

    typedef enum logic [2:0] {
        SFF_LANE_1 = 3'b001,
        SFF_LANE_2 = 3'b010,
        SFF_LANE_4 = 3'b100
    } sff_lane_e;

    typedef struct packed {
        logic lane_three;
        logic lane_two;
        logic lane_one;
        logic lane_zero;
    } sff_lanes_s;

    typedef struct packed {
        logic valid;
        logic first;
        logic [7:0] data;
    } sff_rx_s;

endpackage : sff_pkg

// ===== sff_fifo.sv
`timescale 1ns/10ps
module sff_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // fill side
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    // drain side
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
            $error("fifo depth must be a power of two, at least 2");
        end
        if (WIDTH < 1) begin : g_bad_width
            $error("fifo width must be at least 1");
        end
    endgenerate

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready_o = (cnt_q != DEPTH[AW:0]);
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o = mem_q[rd_q];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

endmodule : sff_fifo

// ===== sff_front_end.sv
`timescale 1ns/10ps
module sff_front_end #(
    parameter int TX_DEPTH = sff_pkg::SFF_TX_DEPTH
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // serial pins
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire sff_pkg::sff_lanes_s lanes_i,
    output sff_pkg::sff_lanes_s lanes_o,
    output sff_pkg::sff_lanes_s lanes_oe_n_o,
    // settings held by the core
    input wire logic four_lane_enable_i,
    input wire logic [1:0] status_lock_bits_i,
    input wire logic out_phase_i,
    // read data from the core
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    output logic tx_ready_o,
    // received bytes and state to the core
    output sff_pkg::sff_rx_s rx_o,
    output logic selected_o,
    output logic paused_o,
    output logic frame_end_o,
    output sff_pkg::sff_lane_e in_lanes_o,
    output sff_pkg::sff_lane_e out_lanes_o,
    output logic status_write_blocked_o
);
    import sff_pkg::*;

    generate
        if (TX_DEPTH < 2) begin : g_bad_depth
            $error("tx depth must be at least 2");
        end
    endgenerate

    // ==========================================================
    // helpers
    // ==========================================================
    function automatic logic [3:0] sff_width(input sff_lane_e mode);
        case (mode)
            SFF_LANE_2: sff_width = 4'h2;
            SFF_LANE_4: sff_width = 4'h4;
            default: sff_width = 4'h1;
        endcase
    endfunction : sff_width

    function automatic logic [3:0] sff_drive_mask(input sff_lane_e mode);
        case (mode)
            SFF_LANE_2: sff_drive_mask = 4'h3;
            SFF_LANE_4: sff_drive_mask = 4'hF;
            default: sff_drive_mask = 4'h2;
        endcase
    endfunction : sff_drive_mask

    // ==========================================================
    // pin synchronisers
    // ==========================================================
    logic [SFF_SYNC_W-1:0] sync1_q;
    logic [SFF_SYNC_W-1:0] sync2_q;
    logic sclk_s;
    logic cs_n_s;
    logic [3:0] lane_s;
    logic sclk_prev_q;
    logic cs_n_prev_q;
    logic [1:0] flush_q;
    logic high_seen_q;

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            sync1_q <= SFF_SYNC_RST;
            sync2_q <= SFF_SYNC_RST;
        end else begin
            sync1_q <= {sclk_i, cs_n_i, lanes_i};
            sync2_q <= sync1_q;
        end
    end

    assign sclk_s = sync2_q[5];
    assign cs_n_s = sync2_q[4];
    assign lane_s = sync2_q[3:0];

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            sclk_prev_q <= 1'b1;
            cs_n_prev_q <= 1'b1;
            flush_q <= 2'b00;
            high_seen_q <= 1'b0;
        end else begin
            sclk_prev_q <= sclk_s;
            cs_n_prev_q <= cs_n_s;
            flush_q <= {flush_q[0], 1'b1};
            // select high counts only once the syncs carry real pin levels
            high_seen_q <= high_seen_q | (flush_q[1] & cs_n_s);
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;

    // mode 0 and mode 3 both idle the clock away from the select edges,
    // so edges seen only while selected are real data edges
    assign sclk_rise = sclk_s & ~sclk_prev_q;
    assign sclk_fall = ~sclk_s & sclk_prev_q;
    assign cs_fall = cs_n_prev_q & ~cs_n_s & high_seen_q;
    assign cs_rise = ~cs_n_prev_q & cs_n_s;

    // ==========================================================
    // arming after reset
    // ==========================================================
    logic armed_q;

    // select already low at reset release does not count as a fall
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            armed_q <= 1'b0;
        end else if (cs_fall) begin
            armed_q <= 1'b1;
        end
    end

    // ==========================================================
    // pause
    // ==========================================================
    sff_state_e state_q;
    sff_state_e state_d;
    logic paused_q;
    logic pause_allowed;

    assign pause_allowed = ~four_lane_enable_i & ~cs_n_s & (state_q != SFF_ST_IDLE);

    // pause follows the hold level only while the link clock is low,
    // which gives both the immediate and the after-falling-edge cases
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            paused_q <= 1'b0;
        end else if (!pause_allowed) begin
            paused_q <= 1'b0;
        end else if (!sclk_s) begin
            paused_q <= ~lane_s[3];
        end
    end

    logic rise_ok;
    logic fall_ok;

    assign rise_ok = sclk_rise & ~paused_q & ~cs_n_s;
    assign fall_ok = sclk_fall & ~paused_q & ~cs_n_s;

    // ==========================================================
    // instruction and receive path
    // ==========================================================
    sff_lane_e in_mode_q;
    sff_lane_e out_mode_q;
    logic [7:0] in_sh_q;
    logic [3:0] in_bits_q;
    logic [7:0] in_byte;
    logic [3:0] in_w;
    logic sample_en;
    logic byte_done;
    sff_rx_s rx_q;

    assign in_w = sff_width(in_mode_q);
    assign sample_en = rise_ok & ((state_q == SFF_ST_INSTR) |
                       ((state_q == SFF_ST_BODY) & ((in_mode_q == SFF_LANE_1) | ~out_phase_i)));
    assign byte_done = sample_en & ((in_bits_q + in_w) == SFF_BITS_PER_BYTE);

    always_comb begin
        case (in_mode_q)
            SFF_LANE_2: in_byte = {in_sh_q[5:0], lane_s[1], lane_s[0]};
            SFF_LANE_4: in_byte = {in_sh_q[3:0], lane_s};
            default: in_byte = {in_sh_q[6:0], lane_s[0]};
        endcase
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            SFF_ST_IDLE: begin
                if (cs_fall) begin
                    state_d = SFF_ST_INSTR;
                end
            end
            SFF_ST_INSTR: begin
                if (byte_done) begin
                    state_d = SFF_ST_BODY;
                end
            end
            SFF_ST_BODY: state_d = SFF_ST_BODY;
            default: state_d = SFF_ST_IDLE;
        endcase
        if (cs_n_s || !armed_q && !cs_fall) begin
            state_d = SFF_ST_IDLE;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state_q <= SFF_ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // shifter and bit count keep their value through a pause
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            in_sh_q <= 8'h00;
            in_bits_q <= SFF_BITS_RST;
        end else if (state_q == SFF_ST_IDLE) begin
            in_sh_q <= 8'h00;
            in_bits_q <= SFF_BITS_RST;
        end else if (byte_done) begin
            in_sh_q <= in_byte;
            in_bits_q <= SFF_BITS_RST;
        end else if (sample_en) begin
            in_sh_q <= in_byte;
            in_bits_q <= in_bits_q + in_w;
        end
    end

    // quad codes fall back to one lane unless four lanes are enabled
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            in_mode_q <= SFF_LANE_1;
            out_mode_q <= SFF_LANE_1;
        end else if (state_q == SFF_ST_IDLE) begin
            in_mode_q <= SFF_LANE_1;
            out_mode_q <= SFF_LANE_1;
        end else if (byte_done && state_q == SFF_ST_INSTR) begin
            case (in_byte)
                SFF_OP_DUAL_OUT: begin
                    out_mode_q <= SFF_LANE_2;
                end
                SFF_OP_DUAL_IO: begin
                    in_mode_q <= SFF_LANE_2;
                    out_mode_q <= SFF_LANE_2;
                end
                SFF_OP_QUAD_OUT: begin
                    if (four_lane_enable_i) begin
                        out_mode_q <= SFF_LANE_4;
                    end
                end
                SFF_OP_QUAD_IO, SFF_OP_QUAD_WORD, SFF_OP_QUAD_OCTAL: begin
                    if (four_lane_enable_i) begin
                        in_mode_q <= SFF_LANE_4;
                        out_mode_q <= SFF_LANE_4;
                    end
                end
                default: begin
                    in_mode_q <= SFF_LANE_1;
                    out_mode_q <= SFF_LANE_1;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            rx_q <= '0;
        end else begin
            rx_q.valid <= byte_done;
            if (byte_done) begin
                rx_q.first <= (state_q == SFF_ST_INSTR);
                rx_q.data <= in_byte;
            end
        end
    end

    // ==========================================================
    // transmit path
    // ==========================================================
    logic fifo_valid;
    logic [7:0] fifo_data;
    logic fifo_pop;
    logic out_active;
    logic [7:0] out_sh_q;
    logic [3:0] out_bits_q;
    logic [3:0] out_w;
    logic [7:0] next_byte;
    sff_lanes_s out_q;

    sff_fifo #(
        .WIDTH(SFF_BYTE_W),
        .DEPTH(TX_DEPTH)
    ) u_tx_fifo (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(tx_valid_i),
        .in_data_i(tx_data_i),
        .in_ready_o(tx_ready_o),
        .out_valid_o(fifo_valid),
        .out_data_o(fifo_data),
        .out_ready_i(fifo_pop)
    );

    assign out_w = sff_width(out_mode_q);
    assign out_active = (state_q == SFF_ST_BODY) & out_phase_i;
    assign fifo_pop = fall_ok & out_active & (out_bits_q == SFF_BITS_RST);
    // an empty buffer sends idle ones rather than stalling the link clock
    assign next_byte = (out_bits_q == SFF_BITS_RST) ?
                       (fifo_valid ? fifo_data : SFF_IDLE_BYTE) : out_sh_q;

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            out_sh_q <= 8'h00;
            out_bits_q <= SFF_BITS_RST;
            out_q <= '0;
        end else if (state_q == SFF_ST_IDLE) begin
            out_sh_q <= 8'h00;
            out_bits_q <= SFF_BITS_RST;
            out_q <= '0;
        end else if (fall_ok && out_active) begin
            out_sh_q <= next_byte << out_w;
            out_bits_q <= (out_bits_q == SFF_BITS_RST) ?
                          (SFF_BITS_PER_BYTE - out_w) : (out_bits_q - out_w);
            case (out_mode_q)
                SFF_LANE_2: out_q <= {2'b00, next_byte[7], next_byte[6]};
                SFF_LANE_4: out_q <= next_byte[7:4];
                default: out_q <= {2'b00, next_byte[7], 1'b0};
            endcase
        end
    end

    // ==========================================================
    // pin drive and core status
    // ==========================================================
    logic drive;

    assign drive = out_active & ~paused_q & ~cs_n_s;
    assign lanes_o = out_q;
    assign lanes_oe_n_o = ~(sff_drive_mask(out_mode_q) & {4{drive}});

    // the protect pin counts only while it is not carrying lane two
    assign status_write_blocked_o = status_lock_bits_i[1] |
        ((status_lock_bits_i == SFF_LOCK_HW) & ~lane_s[2] & ~four_lane_enable_i);

    // only a notice; any program or erase in the core runs on regardless
    assign frame_end_o = cs_rise;
    assign rx_o = rx_q;
    assign selected_o = (state_q != SFF_ST_IDLE);
    assign paused_o = paused_q;
    assign in_lanes_o = in_mode_q;
    assign out_lanes_o = out_mode_q;

endmodule : sff_front_end

// ===== sff_props.sv
`timescale 1ns/10ps
module sff_props
    import sff_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // watched ports
    input wire logic sclk_i,
    input wire sff_pkg::sff_lanes_s lanes_o,
    input wire sff_pkg::sff_lanes_s lanes_oe_n_o,
    input wire logic four_lane_enable_i,
    input wire logic [1:0] status_lock_bits_i,
    input wire sff_pkg::sff_rx_s rx_o,
    input wire logic selected_o,
    input wire logic paused_o,
    input wire logic frame_end_o,
    input wire sff_pkg::sff_lane_e out_lanes_o,
    input wire logic status_write_blocked_o
);
    // ======
    // lane drive
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    a_idle_released:
    assert property (!selected_o |-> lanes_oe_n_o == 4'hF) else $error("lanes driven idle");
    a_pause_released:
    assert property (paused_o |-> lanes_oe_n_o == 4'hF) else $error("lanes driven paused");
    a_single_lane_only:
    assert property (selected_o && out_lanes_o == SFF_LANE_1 |-> (lanes_oe_n_o & 4'hD) == 4'hD)
        else $error("extra lane driven");
    // pin fall reaches the output through two syncs, so look two back
    a_fall_shift:
    assert property (selected_o && $past(selected_o) && $changed(lanes_o) |-> !$past(sclk_i, 2))
        else $error("output moved off a falling edge");
    a_quad_enabled:
    assert property (selected_o && out_lanes_o == SFF_LANE_4 |-> four_lane_enable_i)
        else $error("four lanes without enable");
    // ======
    // pause and framing
    a_no_quad_pause:
    assert property (four_lane_enable_i && !paused_o |=> !paused_o) else $error("pause in quad");
    a_pause_selected:
    assert property (!selected_o |-> !paused_o) else $error("pause while deselected");
    a_frame_end_idle:
    assert property (frame_end_o |=> !selected_o && !paused_o) else $error("frame end kept state");
    a_rx_byte_gap:
    assert property (rx_o.valid |=> (!rx_o.valid) [*8]) else $error("byte under eight bits");
    a_lock_blocks:
    assert property (status_lock_bits_i[1] |-> status_write_blocked_o) else $error("lock ignored");
    a_quad_no_protect:
    assert property (four_lane_enable_i && status_lock_bits_i == 2'h1 |-> !status_write_blocked_o)
        else $error("protect pin active in quad");

    c_instr: cover property (rx_o.valid && rx_o.first);
    c_pause: cover property ($rose(paused_o));
    c_quad: cover property (selected_o && out_lanes_o == SFF_LANE_4);
    c_block: cover property (status_write_blocked_o && !status_lock_bits_i[1]);
endmodule : sff_props

// ===== sff_host.sv
`timescale 1ns/10ps
module sff_host (
    // clock
    input wire logic mclk_i,
    // resolved lane pins
    input wire logic [3:0] pin_i,
    // host pins
    output logic sclk_o,
    output logic cs_n_o,
    output logic [3:0] val_o
);
    logic [3:0] drv_q = 4'hD;
    logic [3:0] set_q = 4'hF;
    logic [7:0] rd_q = 8'h00;
    logic m3_q = 1'b0;

    // select low from power-up, so no fall has been seen yet
    initial cs_n_o = 1'b0;
    initial sclk_o = 1'b0;
    initial val_o = 4'hF;
    // released lanes toggle so stale bits never look valid
    always @(posedge mclk_i) begin
        val_o <= (drv_q & set_q) | (~drv_q & ~val_o);
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : tick

    task automatic pins(input logic [3:0] m, input logic [3:0] v);
        drv_q <= m;
        set_q <= v;
    endtask : pins

    // ======
    // framing: clock rests at the mode level across select edges
    task automatic begin_frame(input logic m3);
        m3_q = m3;
        sclk_o <= m3;
        tick(4);
        cs_n_o <= 1'b0;
        tick(4);
    endtask : begin_frame

    task automatic end_frame;
        sclk_o <= m3_q;
        tick(4);
        cs_n_o <= 1'b1;
        tick(4);
    endtask : end_frame

    // ======
    // bits set on the fall, msb first, read just before the next fall
    task automatic shift(input logic [7:0] b, input int w, input int n);
        for (int k = 0; k < n; k += w) begin
            sclk_o <= 1'b0;
            if (w == 1) set_q[0] <= b[7];
            else if (w == 2) set_q[1:0] <= b[7:6];
            else set_q <= b[7:4];
            b = b << w;
            tick(4);
            sclk_o <= 1'b1;
            tick(3);
            @(negedge mclk_i);
            case (w)
                1: rd_q = {rd_q[6:0], pin_i[1]};
                2: rd_q = {rd_q[5:0], pin_i[1:0]};
                default: rd_q = {rd_q[3:0], pin_i};
            endcase
            tick(1);
        end
    endtask : shift

    // clock pulses with moving data; ends with the clock low
    task automatic junk(input int n);
        sclk_o <= 1'b0;
        tick(4);
        repeat (n) begin
            sclk_o <= 1'b1;
            set_q[0] <= ~set_q[0];
            tick(4);
            sclk_o <= 1'b0;
            tick(4);
        end
    endtask : junk
endmodule : sff_host

// ===== tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import sff_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic en = 1'b0;
    logic [1:0] lock = 2'h0;
    logic oph = 1'b0;
    logic txv = 1'b0;
    logic [7:0] txd = 8'h00;
    logic txr, sel, psd, fend, blk, sclk, cs_n;
    logic [3:0] hval;
    sff_lanes_s pins, dout, oe_n;
    sff_rx_s rx;
    sff_lane_e inl, outl;
    sff_rx_s rxq[$];
    int num_errors = 0;
    int checked = 0;

    // device wins where it drives, otherwise the host side
    assign pins = (oe_n & hval) | (~oe_n & dout);
    initial begin
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) if (rx.valid === 1'b1) rxq.push_back(rx);

    sff_front_end sff_front_end_i (.mclk_i(mclk), .rst_n_i(rst_n), .sclk_i(sclk),
        .cs_n_i(cs_n), .lanes_i(pins), .lanes_o(dout), .lanes_oe_n_o(oe_n),
        .four_lane_enable_i(en), .status_lock_bits_i(lock), .out_phase_i(oph),
        .tx_valid_i(txv), .tx_data_i(txd), .tx_ready_o(txr), .rx_o(rx), .selected_o(sel),
        .paused_o(psd), .frame_end_o(fend), .in_lanes_o(inl), .out_lanes_o(outl),
        .status_write_blocked_o(blk));
    sff_host sff_host_i (.mclk_i(mclk), .pin_i(pins), .sclk_o(sclk), .cs_n_o(cs_n),
        .val_o(hval));

    // ======
    // helpers
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick

    task automatic complete_run;
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : complete_run

    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask : chk8

    task automatic chk1(input string nm, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s exp %b got %b", nm, e, g);
        end
    endtask : chk1

    task automatic get_rx(input logic f, input logic [7:0] d);
        sff_rx_s r;
        for (int i = 0; i < 20 && rxq.size() == 0; i++) tick(1);
        if (rxq.size() == 0) begin
            num_errors++;
            complete_run();
        end else begin
            r = rxq.pop_front();
            chk1("rx first", f, r.first);
            chk8("rx data", d, r.data);
        end
    endtask : get_rx

    task automatic push(input logic [7:0] b);
        txv <= 1'b1;
        txd <= b;
        tick(1);
        txv <= 1'b0;
    endtask : push

    task automatic open(input logic m3);
        rxq.delete();
        sff_host_i.begin_frame(m3);
    endtask : open

    // ======
    // scenarios
    task automatic t_no_arm;
        sff_host_i.shift(8'h03, 1, 8);
        tick(8);
        chk8("rx count", 8'h00, 8'(rxq.size()));
        chk1("selected", 1'b0, sel);
        sff_host_i.end_frame();
    endtask : t_no_arm

    task automatic t_fifo;
        int n = 0;
        txv <= 1'b1;
        txd <= 8'h10;
        repeat (20) begin
            @(negedge mclk);
            if (txr === 1'b1) n++;
            @(posedge mclk);
            txd <= txd + 8'h01;
        end
        txv <= 1'b0;
        chk8("fifo fill", 8'h10, 8'(n));
        open(1'b0);
        sff_host_i.shift(8'h03, 1, 8);
        get_rx(1'b1, 8'h03);
        oph <= 1'b1;
        for (int i = 0; i < 17; i++) begin
            sff_host_i.shift(8'h00, 1, 8);
            chk8("read", (i < 16) ? 8'(16 + i) : SFF_IDLE_BYTE, sff_host_i.rd_q);
        end
        oph <= 1'b0;
        sff_host_i.end_frame();
    endtask : t_fifo

    task automatic t_dual;
        push(8'hC6);
        open(1'b1);
        sff_host_i.shift(SFF_OP_DUAL_IO, 1, 8);
        get_rx(1'b1, SFF_OP_DUAL_IO);
        chk8("in lanes", 8'(SFF_LANE_2), 8'(inl));
        sff_host_i.pins(4'hF, 4'hF);
        sff_host_i.shift(8'h5A, 2, 8);
        get_rx(1'b0, 8'h5A);
        sff_host_i.pins(4'hC, 4'hF);
        oph <= 1'b1;
        sff_host_i.shift(8'h00, 2, 8);
        chk8("dual read", 8'hC6, sff_host_i.rd_q);
        oph <= 1'b0;
        sff_host_i.end_frame();
        sff_host_i.pins(4'hD, 4'hF);
        open(1'b0);
        sff_host_i.shift(SFF_OP_DUAL_OUT, 1, 8);
        tick(2);
        chk8("dual out lanes", 8'(SFF_LANE_2), 8'(outl));
        chk8("dual out in lanes", 8'(SFF_LANE_1), 8'(inl));
        sff_host_i.end_frame();
    endtask : t_dual

    task automatic t_quad;
        logic [7:0] ops [4] = '{SFF_OP_QUAD_IO, SFF_OP_QUAD_WORD, SFF_OP_QUAD_OCTAL,
            SFF_OP_QUAD_OUT};
        open(1'b0);
        sff_host_i.shift(SFF_OP_QUAD_IO, 1, 8);
        tick(2);
        chk8("quad refused", 8'(SFF_LANE_1), 8'(inl));
        sff_host_i.end_frame();
        en <= 1'b1;
        push(8'h93);
        foreach (ops[i]) begin
            open(1'b0);
            sff_host_i.shift(ops[i], 1, 8);
            tick(2);
            chk8("quad lanes", 8'(SFF_LANE_4), 8'(outl));
            if (i == 3) begin
                // hold lane released and toggling: no pause may follow
                sff_host_i.pins(4'h0, 4'hF);
                oph <= 1'b1;
                sff_host_i.shift(8'h00, 4, 8);
                chk8("quad read", 8'h93, sff_host_i.rd_q);
                oph <= 1'b0;
            end
            sff_host_i.end_frame();
        end
        en <= 1'b0;
        sff_host_i.pins(4'hD, 4'hF);
    endtask : t_quad

    task automatic t_hold;
        open(1'b0);
        sff_host_i.shift(8'h9C, 1, 4);
        sff_host_i.pins(4'hD, 4'h7);
        tick(6);
        chk1("pause early", 1'b0, psd);
        sff_host_i.junk(0);
        tick(2);
        chk1("pause entry", 1'b1, psd);
        sff_host_i.junk(3);
        sff_host_i.pins(4'hD, 4'hF);
        tick(6);
        chk1("pause exit", 1'b0, psd);
        sff_host_i.shift(8'hC0, 1, 4);
        get_rx(1'b1, 8'h9C);
        sff_host_i.pins(4'hD, 4'h7);
        sff_host_i.junk(0);
        tick(2);
        // select raised in mid-pause on purpose
        sff_host_i.end_frame();
        tick(6);
        chk1("pause cleared", 1'b0, psd);
        chk1("selected", 1'b0, sel);
        sff_host_i.pins(4'hD, 4'hF);
    endtask : t_hold

    task automatic t_protect;
        // {enable, lock, protect pin, blocked}
        logic [4:0] tbl [6] = '{5'h00, 5'h05, 5'h06, 5'h0B, 5'h0D, 5'h14};
        foreach (tbl[i]) begin
            en <= tbl[i][4];
            lock <= tbl[i][3:2];
            sff_host_i.pins(4'hD, {1'b1, tbl[i][1], 2'b11});
            tick(5);
            chk1("write block", tbl[i][0], blk);
        end
        en <= 1'b0;
        lock <= 2'h0;
        sff_host_i.pins(4'hD, 4'hF);
    endtask : t_protect

    initial begin
        tick(5);
        rst_n <= 1'b1;
        tick(3);
        t_no_arm();
        t_fifo();
        t_dual();
        t_quad();
        t_hold();
        t_protect();
        complete_run();
    end

    initial begin
        tick(90000);
        num_errors++;
        complete_run();
    end
endmodule : tb_top

bind sff_front_end sff_props sff_props_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .sclk_i(sclk_i),
    .lanes_o(lanes_o), .lanes_oe_n_o(lanes_oe_n_o), .four_lane_enable_i(four_lane_enable_i),
    .status_lock_bits_i(status_lock_bits_i), .rx_o(rx_o), .selected_o(selected_o),
    .paused_o(paused_o), .frame_end_o(frame_end_o), .out_lanes_o(out_lanes_o),
    .status_write_blocked_o(status_write_blocked_o));
